// ### src/acc_pkg.sv
// Constants shared by the converter control and status block
package acc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_TRIG   = 3'h3;
  localparam logic [2:0] IDX_RES_LO = 3'h4;
  localparam logic [2:0] IDX_RES_HI = 3'h5;
  localparam logic [2:0] IDX_CTRL   = 3'h6;
  localparam logic [2:0] IDX_MUX    = 3'h7;
  // Reset values
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_MUX    = 8'h00;
  localparam logic [2:0] RST_TRIG   = 3'h0;
  // converter_control_status fields
  localparam int CTRL_EN    = 7;
  localparam int CTRL_START = 6;
  localparam int CTRL_ATE   = 5;
  localparam int CTRL_FLAG  = 4;
  localparam int CTRL_IE    = 3;
  localparam int CTRL_DIV   = 0;
  // input_reference_select fields
  localparam int MUX_REF1 = 7;
  localparam int MUX_REF0 = 6;
  localparam int MUX_LAR  = 5;
  localparam int MUX_REF2 = 4;
  localparam int MUX_CH   = 0;
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] LEN_NORMAL = 5'h0D;
  localparam logic [4:0] LEN_INIT   = 5'h19;
  // Trigger source code for free running
  localparam logic [2:0] TRIG_FREE  = 3'h0;
  // Reference kinds presented to the analog core
  localparam logic [2:0] REF_SUPPLY   = 3'h0;
  localparam logic [2:0] REF_PIN      = 3'h1;
  localparam logic [2:0] REF_INT1V1   = 3'h2;
  localparam logic [2:0] REF_RESERVED = 3'h3;
  localparam logic [2:0] REF_INT2V56  = 3'h4;
  localparam logic [2:0] REF_INT2V56B = 3'h5;
  // Single-ended sources beyond the four external inputs
  localparam logic [2:0] SE_BANDGAP = 3'h4;
  localparam logic [2:0] SE_GROUND  = 3'h5;
  localparam logic [2:0] SE_TEMP    = 3'h6;
  localparam logic [2:0] SE_NONE    = 3'h7;
endpackage

// ### src/acc_ctrl.sv
// Converter control and status registers with prescaler and sequencing
//
// What this block does
// - Reference bits pick supply, pin, 1.1V or 2.56V
// - Reference change waits for running conversion end
// - Reference change makes next conversion 25 cycles
// - Left-adjust bit reshapes result view immediately
// - Channel codes pick inputs, bandgap, ground, temperature
// - Codes 4-11 pick differential pairs, odd gain20
// - Channel change waits for running conversion end
// - Enable off aborts any running conversion
// - Start bit starts one or first free-run conversion
// - First conversion after enable takes 25 cycles
// - Start reads one while busy; zero ignored
// - Auto trigger starts on selected rising edge
// - Flag sets at every completion, even with result locked
// - Flag clears on vector acknowledge or written one
// - Interrupt request needs flag, enable, global enable
// - Divider codes give clock divide 2 to 128
// - Trigger source selects free run or event
// - Low byte read locks result until high read
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [5:0]  trig_i,
  input  wire logic        gie_i,
  input  wire logic        irq_ack_i,
  input  wire logic [9:0]  result_i,
  output logic             irq_o,
  output logic             conv_busy_o,
  output logic             conv_tick_o,
  output logic             conv_long_o,
  output logic [2:0]       ref_kind_o,
  output logic             diff_o,
  output logic             gain20_o,
  output logic [2:0]       pos_sel_o,
  output logic [2:0]       neg_sel_o
);

  typedef enum logic {ST_IDLE, ST_CONV} acc_state_t;

  acc_state_t state_r;
  logic       en_r, ate_r, ie_r, flag_r, ack_r, lock_r;
  logic       long_pend_r, tick_r, trig_prev_r;
  logic [2:0] div_r, trig_src_r, act_ref_r;
  logic [3:0] act_ch_r;
  logic [7:0] mux_r, rdata;
  logic [6:0] pre_cnt_r, div_max;
  logic [4:0] cnt_r, len_r;
  logic [9:0] result_r;
  logic [31:0] dat_r;
  logic       acc, rd, wr, wr_ctrl, en_rise, en_fall, wr_start;
  logic       busy, done, free_run, load_active, ref_diff, long_now;
  logic       trig_sel, trig_edge, start_go;
  logic [2:0] idx, ref_field;
  logic [7:0] wdat, trig_vec;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, unmapped reads give zero
  assign idx  = wb_adr_i[4:2];
  assign wdat = wb_dat_i[7:0];
  assign acc  = wb_cyc_i & wb_stb_i & ~ack_r;
  assign rd   = acc & ~wb_we_i;
  assign wr   = acc & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end
  always_comb begin
    case (idx)
      acc_pkg::IDX_TRIG:   rdata = {5'h00, trig_src_r};
      acc_pkg::IDX_RES_LO: rdata = mux_r[acc_pkg::MUX_LAR] ?
                                   {result_r[1:0], 6'h00} : result_r[7:0];
      acc_pkg::IDX_RES_HI: rdata = mux_r[acc_pkg::MUX_LAR] ?
                                   result_r[9:2] : {6'h00, result_r[9:8]};
      acc_pkg::IDX_CTRL:   rdata = {en_r, busy, ate_r, flag_r, ie_r, div_r};
      acc_pkg::IDX_MUX:    rdata = mux_r;
      default:             rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (rd) begin
      dat_r <= {24'h00_0000, rdata};
    end
  end
  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  assign wr_ctrl  = wr & (idx == acc_pkg::IDX_CTRL);
  assign en_rise  = wr_ctrl & wdat[acc_pkg::CTRL_EN] & ~en_r;
  assign en_fall  = wr_ctrl & ~wdat[acc_pkg::CTRL_EN];
  assign wr_start = wr_ctrl & wdat[acc_pkg::CTRL_START] & wdat[acc_pkg::CTRL_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r  <= acc_pkg::RST_CTRL[acc_pkg::CTRL_EN];
      ate_r <= acc_pkg::RST_CTRL[acc_pkg::CTRL_ATE];
      ie_r  <= acc_pkg::RST_CTRL[acc_pkg::CTRL_IE];
      div_r <= acc_pkg::RST_CTRL[acc_pkg::CTRL_DIV +: 3];
    end else if (wr_ctrl) begin
      en_r  <= wdat[acc_pkg::CTRL_EN];
      ate_r <= wdat[acc_pkg::CTRL_ATE];
      ie_r  <= wdat[acc_pkg::CTRL_IE];
      div_r <= wdat[acc_pkg::CTRL_DIV +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_r      <= acc_pkg::RST_MUX;
      trig_src_r <= acc_pkg::RST_TRIG;
    end else if (wr && idx == acc_pkg::IDX_MUX) begin
      mux_r <= wdat;
    end else if (wr && idx == acc_pkg::IDX_TRIG) begin
      trig_src_r <= wdat[2:0];
    end
  end
  // Flag clear, a completion in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else if (done) begin
      flag_r <= 1'b1;
    end else if (irq_ack_i || (wr_ctrl && wdat[acc_pkg::CTRL_FLAG])) begin
      flag_r <= 1'b0;
    end
  end
  assign irq_o = flag_r & ie_r & gie_i;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler
  function automatic logic [6:0] div_max_f(input logic [2:0] c);
    div_max_f = (c <= 3'h1) ? 7'h01 : 7'((8'h01 << c) - 8'h01);
  endfunction
  assign div_max = div_max_f(div_r);
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_r || en_fall) begin
      pre_cnt_r <= 7'h00;
      tick_r    <= 1'b0;
    end else begin
      tick_r    <= pre_cnt_r >= div_max;
      pre_cnt_r <= (pre_cnt_r >= div_max) ? 7'h00 : pre_cnt_r + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Triggering and sequencing
  assign busy     = state_r == ST_CONV;
  assign done     = busy & tick_r & ~en_fall & (cnt_r == len_r - 5'h01);
  assign free_run = en_r & ate_r & (trig_src_r == acc_pkg::TRIG_FREE);
  assign trig_vec = {1'b0, trig_i, 1'b0};
  assign trig_sel = trig_vec[trig_src_r];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_sel;
    end
  end
  // Rising edge of the selected source
  assign trig_edge = en_r & ate_r & trig_sel & ~trig_prev_r;
  // Start by write, trigger edge or free-run restart
  assign start_go = ~en_fall & ((~busy & (wr_start | trig_edge)) | (done & free_run));
  // Disable aborts without setting the flag
  always_ff @(posedge clk_i) begin
    if (rst_i || en_fall) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (start_go) state_r <= ST_CONV;
        ST_CONV: if (done && !start_go) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || en_fall || start_go) begin
      cnt_r <= 5'h00;
    end else if (busy && tick_r) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  // Reference and channel load only between conversions
  assign load_active = ~busy | done;
  assign ref_field   = {mux_r[acc_pkg::MUX_REF2], mux_r[acc_pkg::MUX_REF1],
                        mux_r[acc_pkg::MUX_REF0]};
  assign ref_diff    = ref_field != act_ref_r;
  assign long_now    = long_pend_r | en_rise | (load_active & ref_diff);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_ref_r <= 3'h0;
      act_ch_r  <= 4'h0;
    end else if (load_active) begin
      act_ref_r <= ref_field;
      act_ch_r  <= mux_r[acc_pkg::MUX_CH +: 4];
    end
  end
  // Long conversion owed after reference change or enable
  always_ff @(posedge clk_i) begin
    if (rst_i || start_go) begin
      long_pend_r <= 1'b0;
    end else if (en_rise || (load_active && ref_diff)) begin
      long_pend_r <= 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_r <= acc_pkg::LEN_NORMAL;
    end else if (start_go) begin
      len_r <= long_now ? acc_pkg::LEN_INIT : acc_pkg::LEN_NORMAL;
    end
  end
  // Result lock between low and high byte reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r <= 1'b0;
    end else if (rd && idx == acc_pkg::IDX_RES_LO) begin
      lock_r <= 1'b1;
    end else if (rd && idx == acc_pkg::IDX_RES_HI) begin
      lock_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_r <= 10'h000;
    end else if (done && !lock_r) begin
      result_r <= result_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog core controls, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_kind_o <= acc_pkg::REF_SUPPLY;
      diff_o     <= 1'b0;
      gain20_o   <= 1'b0;
      pos_sel_o  <= 3'h0;
      neg_sel_o  <= 3'h0;
    end else begin
      case (act_ref_r)
        3'h2:    ref_kind_o <= acc_pkg::REF_INT1V1;
        3'h3:    ref_kind_o <= acc_pkg::REF_RESERVED;
        3'h6:    ref_kind_o <= acc_pkg::REF_INT2V56;
        3'h7:    ref_kind_o <= acc_pkg::REF_INT2V56B;
        default: ref_kind_o <= act_ref_r[0] ? acc_pkg::REF_PIN : acc_pkg::REF_SUPPLY;
      endcase
      diff_o   <= act_ch_r[3] ^ act_ch_r[2];
      gain20_o <= (act_ch_r[3] ^ act_ch_r[2]) & act_ch_r[0];
      neg_sel_o <= {2'h0, act_ch_r[1]} + (act_ch_r[3] ? 3'h0 : 3'h2);
      case (act_ch_r)
        4'hC:    pos_sel_o <= acc_pkg::SE_BANDGAP;
        4'hD:    pos_sel_o <= acc_pkg::SE_GROUND;
        4'hE:    pos_sel_o <= acc_pkg::SE_NONE;
        4'hF:    pos_sel_o <= acc_pkg::SE_TEMP;
        default: pos_sel_o <= act_ch_r[3:2] == 2'h0 ? act_ch_r[2:0] :
                              (act_ch_r[3] ? 3'h0 : 3'h2);
      endcase
    end
  end

  assign conv_busy_o = busy;
  assign conv_tick_o = tick_r & busy;
  assign conv_long_o = len_r == acc_pkg::LEN_INIT;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_done;
    done ##0 !lock_r;
  endsequence

  chk_flag_on_done: assert property (s_done |=> flag_r && result_r == $past(result_i))
    else $error("flag or result missed at completion");
  chk_lock_hold: assert property (done && lock_r |=> $stable(result_r) && flag_r)
    else $error("locked result changed");
  chk_abort_idle: assert property (en_fall |=> !conv_busy_o && (!flag_r || $past(flag_r)))
    else $error("disable did not abort");
  chk_ref_deferred: assert property (busy && !done |=> $stable(act_ref_r))
    else $error("reference changed mid conversion");
  chk_ch_deferred: assert property (busy && !done |=> $stable(act_ch_r))
    else $error("channel changed mid conversion");
  chk_init_len: assert property (en_rise && wr_start |=>
    conv_busy_o && len_r == acc_pkg::LEN_INIT)
    else $error("first conversion not long");
  chk_irq_gate: assert property (irq_o == (flag_r && ie_r && gie_i))
    else $error("interrupt without its causes");
  chk_flag_clear: assert property (irq_ack_i && !done |=> !flag_r)
    else $error("flag not cleared");
  chk_tick_gap: assert property (tick_r |=> !tick_r)
    else $error("converter clock faster than half rate");
  chk_free_restart: assert property (done && free_run && !en_fall |=> busy && cnt_r == 5'h00)
    else $error("free running did not restart");

endmodule

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the converter control and status block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk, rst, cyc, stb, we, gie, iack;
  logic [4:0]  adr;
  logic [31:0] dat, wb_dat_o;
  logic [5:0]  trig;
  logic [9:0]  rslt;
  logic        wb_ack_o, irq_o, conv_busy_o, conv_tick_o, conv_long_o, diff_o, gain20_o;
  logic [2:0]  ref_kind_o, pos_sel_o, neg_sel_o;
  logic [7:0]  mux, q;
  logic [3:0]  sel;
  logic [15:0] old;
  int          num_errors, checked, cycles, ticks, bcyc, i;

  acc_ctrl i_dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trig_i(trig), .gie_i(gie), .irq_ack_i(iack), .result_i(rslt), .irq_o(irq_o),
    .conv_busy_o(conv_busy_o), .conv_tick_o(conv_tick_o), .conv_long_o(conv_long_o),
    .ref_kind_o(ref_kind_o), .diff_o(diff_o), .gain20_o(gain20_o), .pos_sel_o(pos_sel_o),
    .neg_sel_o(neg_sel_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Expected analog selection: ref kind, diff, gain, positive, negative
  function automatic logic [10:0] dm(input logic [7:0] m);
    logic [2:0] rf, p, ng;
    logic       df;
    int         c;
    c = m[3:0];
    case ({m[7], m[6]})
      2'b00: rf = 3'h0;
      2'b01: rf = 3'h1;
      2'b10: rf = m[4] ? 3'h4 : 3'h2;
      default: rf = m[4] ? 3'h5 : 3'h3;
    endcase
    df = (c >= 4 && c <= 11);
    p = (c < 4) ? 3'(c) : (c == 12) ? 3'h4 : (c == 13) ? 3'h5 : (c == 14) ? 3'h7 : 3'h6;
    ng = (c < 6) ? 3'h2 : (c < 8) ? 3'h3 : (c < 10) ? 3'h0 : 3'h1;
    if (df)
      p = (c < 8) ? 3'h2 : 3'h0;
    return {rf, df, df & m[0], p, df ? ng : 3'h0};
  endfunction

  function automatic logic [15:0] res(input logic [9:0] r, input logic lar);
    return lar ? {r[9:2], r[1:0], 6'h00} : {6'h00, r};
  endfunction

  task automatic chk_dec(input logic [7:0] m);
    chk({ref_kind_o, diff_o, gain20_o, pos_sel_o, diff_o ? neg_sel_o : 3'h0}, dm(m));
  endtask

  // Classic single cycle; holds the request until ack is sampled high
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] rq);
    adr <= {a, 2'b00};
    dat <= {24'h0, d};
    sel <= 4'hF;
    we  <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    // Only the bench timeout ends a missing answer
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rq = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
    chk(wb_ack_o, 0);
  endtask

  task automatic idle;
    int n;
    n = 0;
    while (conv_busy_o !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Start a conversion, optionally change the selection mid-run, then check it
  task automatic go(input logic [7:0] c, input int len, input logic [8:0] mid);
    int dv;
    logic [15:0] rv;
    dv = (c[2:0] < 2) ? 2 : (1 << c[2:0]);
    @(negedge clk);
    ticks = 0;
    bcyc = 0;
    @(posedge clk);
    rslt <= 10'($urandom);
    bus(1, 6, c, q);
    bus(0, 6, 0, q);
    chk(q[6], 1);
    if (mid[8]) begin
      bus(1, 7, mid[7:0], q);
      chk_dec(mux);
      mux = mid[7:0];
    end
    idle();
    repeat (3) @(posedge clk);
    chk(ticks, len);
    chk(bcyc >= (len - 1) * dv && bcyc <= (len + 1) * dv, 1);
    chk(conv_long_o, len == 25);
    chk_dec(mux);
    rv = res(rslt, mux[5]);
    bus(0, 4, 0, q);
    chk(q, rv[7:0]);
    bus(0, 5, 0, q);
    chk(q, rv[15:8]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (conv_tick_o === 1'b1)
      ticks++;
    if (conv_busy_o === 1'b1)
      bcyc++;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    {rst, cyc, stb, we, gie, iack} = 6'h20;
    {adr, dat, trig, rslt, mux, sel} = '0;
    void'($urandom(95496));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, 6, 0, q);
    chk(q, 8'h00); // reset value
    bus(0, 7, 0, q);
    chk(q, 8'h00); // reset value
    bus(0, 1, 0, q);
    chk(q, 8'h00); // unmapped
    // Every channel code, every reference code
    for (i = 0; i < 16; i++) begin
      mux = {i[1], i[0], 1'($urandom), i[2], i[3:0]};
      bus(1, 7, mux, q);
      repeat (2) @(posedge clk);
      chk_dec(mux);
      bus(0, 7, 0, q);
      chk(q, mux);
    end
    mux = 8'h00;
    bus(1, 7, mux, q);
    // Every divider code: initial then normal conversion, flag and irq paths
    for (i = 0; i < 8; i++) begin
      gie <= 1'($urandom);
      go(8'hC8 | 8'(i), 25, 9'h000);
      chk(irq_o, gie);
      bus(1, 6, 8'h98 | 8'(i), q);
      bus(0, 6, 0, q);
      chk(q[4], 0);
      go(8'hC0 | 8'(i), 13, 9'h000);
      chk(irq_o, 0);
      iack <= 1'b1;
      @(posedge clk);
      iack <= 1'b0;
      @(posedge clk);
      bus(0, 6, 0, q);
      chk(q[4], 0);
      bus(1, 6, 0, q);
    end
    go(8'hC0, 25, 9'h000);
    go(8'hC0, 13, 9'h143);
    go(8'hC0, 25, 9'h000);
    go(8'hC0, 13, 9'h000);
    // Left adjust flips the view with no new conversion
    bus(1, 7, 8'h63, q);
    old = res(rslt, 1'b1);
    bus(0, 4, 0, q);
    chk(q, old[7:0]);
    bus(0, 5, 0, q);
    chk(q, old[15:8]);
    bus(1, 7, 8'h43, q);
    // Low byte read freezes the result across a completion
    old = res(rslt, 1'b0);
    bus(0, 4, 0, q);
    rslt <= ~rslt;
    bus(1, 6, 8'hC0, q);
    idle();
    bus(0, 5, 0, q);
    chk(q, old[15:8]);
    // Disable mid-run aborts; writing zero to start does nothing
    bus(1, 6, 8'hC7, q);
    bus(1, 6, 8'h17, q);
    repeat (2) @(posedge clk);
    chk(conv_busy_o, 0);
    bus(0, 6, 0, q);
    chk(q[6:4], 3'h0);
    bus(1, 6, 8'h80, q);
    repeat (2) @(posedge clk);
    chk(conv_busy_o, 0);
    // Auto trigger on source 1 only, one start per rising edge
    bus(1, 3, 8'h01, q);
    bus(0, 3, 0, q);
    chk(q, 8'h01);
    bus(1, 6, 8'hB0, q);
    trig <= 6'h02;
    repeat (3) @(posedge clk);
    chk(conv_busy_o, 0);
    trig <= 6'h01;
    repeat (3) @(posedge clk);
    chk(conv_busy_o, 1);
    idle();
    repeat (5) @(posedge clk);
    chk(conv_busy_o, 0);
    trig <= 6'h00;
    // Free running keeps converting after one start
    bus(1, 3, 8'h00, q);
    bus(1, 6, 8'hF0, q);
    repeat (100) @(posedge clk);
    chk(conv_busy_o, 1);
    bus(1, 6, 8'h00, q);
    repeat (2) @(posedge clk);
    chk(conv_busy_o, 0);
    stop_test();
  end
endmodule

`default_nettype wire
